// ### verilog/dor_pkg.sv
`default_nettype none
package dor_pkg;
	// word and bus geometry
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned ADR_W      = 8;
	localparam int unsigned IDX_W      = 5;
	localparam int unsigned BANK_DEPTH = 19;
	// word indexes; byte address is four times the index
	localparam logic [4:0] IDX_ROW_DOM   = 5'h07;
	localparam logic [4:0] IDX_COL_DOM   = 5'h08;
	localparam logic [4:0] IDX_ROW_HARM  = 5'h09;
	localparam logic [4:0] IDX_COL_HARM  = 5'h0A;
	localparam logic [4:0] IDX_MIN_PWR   = 5'h0B;
	localparam logic [4:0] IDX_HOT_LIMIT = 5'h0C;
	localparam logic [4:0] IDX_TA_FREQ   = 5'h0D;
	localparam logic [4:0] IDX_TA_AMP    = 5'h0E;
	localparam logic [4:0] IDX_TA_PHASE  = 5'h0F;
	localparam logic [4:0] IDX_TB_FREQ   = 5'h10;
	localparam logic [4:0] IDX_TB_AMP    = 5'h11;
	localparam logic [4:0] IDX_TB_PHASE  = 5'h12;
	localparam logic [4:0] IDX_RING_OFS  = 5'h13;
	localparam logic [4:0] IDX_RING_FREQ = 5'h14;
	localparam logic [4:0] IDX_RING_AMP  = 5'h15;
	localparam logic [4:0] IDX_RING_PH   = 5'h16;
	localparam logic [4:0] IDX_MTR_RAMP  = 5'h17;
	localparam logic [4:0] IDX_MTR_AMP   = 5'h18;
	localparam logic [4:0] IDX_MTR_FREQ  = 5'h19;
	localparam logic [4:0] IDX_STATUS    = 5'h1A;
	localparam logic [4:0] BANK_BASE     = 5'h07;
	localparam logic [4:0] BANK_LAST     = 5'h19;
	// ratio scale: this stored value means a ratio of one
	localparam logic [15:0] RATIO_UNITY  = 16'h07F0;
	// ring offset field and its step
	localparam int unsigned RING_OFS_MSB = 5;
	localparam logic [16:0] RING_STEP_MV = 17'h005DC;
	localparam logic [16:0] RING_MAX_MV  = 17'h17124;
	// agc attenuation step, as an arithmetic shift
	localparam int unsigned AGC_SHIFT    = 1;
	// status register bit positions
	localparam int unsigned ST_VALID     = 0;
	localparam int unsigned ST_ROW_DOM   = 1;
	localparam int unsigned ST_COL_DOM   = 2;
	localparam int unsigned ST_ROW_HARM  = 3;
	localparam int unsigned ST_COL_HARM  = 4;
	localparam int unsigned ST_DISCARD   = 5;
	localparam int unsigned ST_AGC_HOT   = 6;
	localparam int unsigned ST_ALL_WR    = 7;
	// bus slave states
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_READ = 3'b010,
		BUS_ACK  = 3'b100
	} dor_bus_st_t;
	// index lies inside the parameter bank
	function automatic logic dor_in_bank(input logic [4:0] idx);
		return (idx >= BANK_BASE) && (idx <= BANK_LAST);
	endfunction
	// bank slot of an index
	function automatic logic [4:0] dor_slot(input logic [4:0] idx);
		return 5'(idx - BANK_BASE);
	endfunction
endpackage
`default_nettype wire

// ### verilog/dor_param_mem.sv
`default_nettype none
// parameter word storage: byte-lane writes, registered read, all words visible
module dor_param_mem (
	input  wire logic         clk_i,
	input  wire logic         we_i,
	input  wire logic [4:0]   wslot_i,
	input  wire logic [1:0]   wbe_i,
	input  wire logic [15:0]  wdata_i,
	input  wire logic [4:0]   rslot_i,
	output logic      [15:0]  rdata_o,
	output logic      [303:0] words_o
);
	// storage array, deliberately without reset
	logic [15:0] mem [0:dor_pkg::BANK_DEPTH-1];

	// write: every bit stored, used or not no reset
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			if (wbe_i[0]) begin
				mem[wslot_i][7:0] <= wdata_i[7:0];
			end
			if (wbe_i[1]) begin
				mem[wslot_i][15:8] <= wdata_i[15:8];
			end
		end
	end

	// registered read port
	always_ff @(posedge clk_i) begin
		rdata_o <= mem[rslot_i];
	end

	// every word driven to the datapaths at all times
	genvar g;
	generate
		for (g = 0; g < dor_pkg::BANK_DEPTH; g++) begin : g_out
			assign words_o[g*16 +: 16] = mem[g];
		end
	endgenerate
endmodule
`default_nettype wire

// ### verilog/dor_ratio_cmp.sv
`default_nettype none
// ratio check without division: num/den > thr/unity
module dor_ratio_cmp (
	input  wire logic [15:0] num_i,
	input  wire logic [15:0] den_i,
	input  wire logic [15:0] thr_i,
	output logic             pass_o
);
	// cross products, 32 bits hold any 16x16 product
	logic [31:0] lhs;
	logic [31:0] rhs;

	assign lhs    = num_i * dor_pkg::RATIO_UNITY;
	assign rhs    = den_i * thr_i;
	// strict: a ratio equal to the threshold fails
	assign pass_o = lhs > rhs;
endmodule
`default_nettype wire

// ### verilog/dor_indirect_bank.sv
// The Wishbone interface to the registers was decided locally.
`default_nettype none
// parameter bank for the dtmf detector and the tone, ring and metering generators
module dor_indirect_bank (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// classic wishbone slave
	// one transfer at a time, fixed two-edge answer
	input  wire logic [7:0]         adr_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	input  wire logic               we_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic               stb_i,
	input  wire logic               cyc_i,
	output logic                    ack_o,
	// detector powers, same clock domain
	// no synchronisers: the powers come from logic on this clock
	input  wire logic               calc_valid_i,
	input  wire logic [15:0]        row_peak_pwr_i,
	input  wire logic [15:0]        row_rest_pwr_i,
	input  wire logic [15:0]        col_peak_pwr_i,
	input  wire logic [15:0]        col_rest_pwr_i,
	input  wire logic [15:0]        row_harm_pwr_i,
	input  wire logic [15:0]        col_harm_pwr_i,
	input  wire logic [15:0]        total_pwr_i,
	output logic                    det_valid_o,
	output logic                    det_discard_o,
	output logic                    det_row_dom_o,
	output logic                    det_col_dom_o,
	output logic                    det_row_harm_o,
	output logic                    det_col_harm_o,
	// detector input agc
	input  wire logic               sample_valid_i,
	input  wire logic signed [15:0] sample_i,
	output logic                    agc_valid_o,
	output logic signed [15:0]      agc_sample_o,
	output logic                    agc_hot_o,
	// tone generator a
	output logic signed [15:0]      tone_a_freq_coef_o,
	output logic signed [15:0]      tone_a_amplitude_o,
	output logic signed [15:0]      tone_a_initial_phase_o,
	// tone generator b
	output logic signed [15:0]      tone_b_freq_coef_o,
	output logic signed [15:0]      tone_b_amplitude_o,
	output logic signed [15:0]      tone_b_initial_phase_o,
	// ringing generator
	output logic [5:0]              ring_dc_offset_o,
	output logic [16:0]             ring_dc_offset_mv_o,
	output logic signed [15:0]      ring_freq_coef_o,
	output logic signed [15:0]      ring_amplitude_o,
	output logic signed [15:0]      ring_initial_phase_o,
	// pulse metering generator
	output logic signed [15:0]      meter_ramp_rate_o,
	output logic signed [15:0]      meter_amplitude_o,
	output logic signed [15:0]      meter_freq_coef_o
);
	// bus state
	dor_pkg::dor_bus_st_t bus_st_reg;
	dor_pkg::dor_bus_st_t bus_st_next;
	// registered read data
	logic [31:0]          dat_reg;
	// bank storage ports
	logic [4:0]           idx;
	logic                 in_bank;
	logic                 bank_we;
	logic [15:0]          mem_rdata;
	logic [303:0]         words;
	// which words were written since reset
	// feeds the status word only
	logic [18:0]          written_reg;
	// detector results
	logic                 low_pwr;
	logic                 row_dom;
	logic                 col_dom;
	logic                 row_harm;
	logic                 col_harm;
	logic                 det_valid_reg;
	logic                 det_discard_reg;
	logic [3:0]           pass_reg;
	// agc
	logic [16:0]          sample_mag;
	logic                 hot;
	logic                 agc_valid_reg;
	logic signed [15:0]   agc_sample_reg;
	logic                 agc_hot_reg;
	// ring offset in millivolts
	logic [16:0]          ring_mv_reg;
	// status word as software sees it
	logic [15:0]          status;

	// address map: one 16-bit word in each 32-bit slot, byte address four
	// times the word index; indexes 0 to 6 and 27 to 31 read as zero
	// and drop writes, index 26 is the read-only status word
	// adr_i[1:0] is ignored, so an unaligned address hits its word
	// word index from the byte address; upper address bit must be clear
	assign idx     = adr_i[6:2];
	assign in_bank = dor_pkg::dor_in_bank(idx) && !adr_i[7];

	// write lands on the edge at which the master samples ack
	assign bank_we = (bus_st_reg == dor_pkg::BUS_ACK) && cyc_i && stb_i && we_i && in_bank;

	// fixed latency: one edge loads the storage read port, the next loads
	// dat_reg, so every access, mapped or not, answers alike and the
	// read path never goes combinational to the bus
	// the master must drop cyc and stb for a cycle after ack: a request
	// still held when idle returns is taken a second time
	// bus state transitions; a request takes three edges to finish
	always_comb begin
		bus_st_next = bus_st_reg;
		case (bus_st_reg)
			dor_pkg::BUS_IDLE: begin
				// new request seen
				if (cyc_i && stb_i) begin
					bus_st_next = dor_pkg::BUS_READ;
				end
			end
			dor_pkg::BUS_READ: begin
				// storage read port loaded, dat_reg loads now
				bus_st_next = dor_pkg::BUS_ACK;
			end
			dor_pkg::BUS_ACK: begin
				// one ack cycle, then idle for at least one cycle
				bus_st_next = dor_pkg::BUS_IDLE;
			end
			default: begin
				// unreachable code: recover to idle
				bus_st_next = dor_pkg::BUS_IDLE;
			end
		endcase
	end

	// bus state register; reset aborts a transfer in flight without ack
	// a master caught by reset must start its cycle again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_st_reg <= dor_pkg::BUS_IDLE;
		end else begin
			bus_st_reg <= bus_st_next;
		end
	end

	// ack straight from the state register
	assign ack_o = (bus_st_reg == dor_pkg::BUS_ACK);

	// read data mux captured into a register; unmapped reads give zero
	// held between accesses; a write also loads it, so dat_o keeps that word's value from before the write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h0000_0000;
		end else if (bus_st_reg == dor_pkg::BUS_READ) begin
			if (in_bank) begin
				// last written value, all 16 bits
				dat_reg <= {16'h0000, mem_rdata};
			end else if (idx == dor_pkg::IDX_STATUS && !adr_i[7]) begin
				dat_reg <= {16'h0000, status};
			end else begin
				// unmapped index or upper half of the map
				dat_reg <= 32'h0000_0000;
			end
		end
	end

	assign dat_o = dat_reg;

	// parameter storage, low two byte lanes only
	// sel_i[3:2] and dat_i[31:16] are ignored: each word is 16 bits wide
	// the write strobe comes from the ack state so a write lands once,
	// at the edge at which the master sees ack
	dor_param_mem u_mem (
		.clk_i   (clk_i),
		.we_i    (bank_we),
		.wslot_i (dor_pkg::dor_slot(idx)),
		.wbe_i   (sel_i[1:0]),
		.wdata_i (dat_i[15:0]),
		.rslot_i (in_bank ? dor_pkg::dor_slot(idx) : 5'h00),
		.rdata_o (mem_rdata),
		.words_o (words)
	);

	// track written words; the contents themselves keep no reset value
	// only a status hint: a word counts as written after any byte lane
	// lands, so a half-written word is still reported as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			written_reg <= 19'h00000;
		end else if (bank_we && sel_i[1:0] != 2'h0) begin
			written_reg[dor_pkg::dor_slot(idx)] <= 1'b1;
		end
	end

	// detector ratio checks
	// no divider: each check multiplies across, peak times unity against
	// other power times threshold, so it settles within the cycle
	// a threshold of zero passes any nonzero peak power
	dor_ratio_cmp u_row_dom (
		.num_i  (row_peak_pwr_i),
		.den_i  (row_rest_pwr_i),
		.thr_i  (words[dor_pkg::dor_slot(dor_pkg::IDX_ROW_DOM)*16 +: 16]),
		.pass_o (row_dom)
	);
	dor_ratio_cmp u_col_dom (
		.num_i  (col_peak_pwr_i),
		.den_i  (col_rest_pwr_i),
		.thr_i  (words[dor_pkg::dor_slot(dor_pkg::IDX_COL_DOM)*16 +: 16]),
		.pass_o (col_dom)
	);
	dor_ratio_cmp u_row_harm (
		.num_i  (row_peak_pwr_i),
		.den_i  (row_harm_pwr_i),
		.thr_i  (words[dor_pkg::dor_slot(dor_pkg::IDX_ROW_HARM)*16 +: 16]),
		.pass_o (row_harm)
	);
	dor_ratio_cmp u_col_harm (
		.num_i  (col_peak_pwr_i),
		.den_i  (col_harm_pwr_i),
		.thr_i  (words[dor_pkg::dor_slot(dor_pkg::IDX_COL_HARM)*16 +: 16]),
		.pass_o (col_harm)
	);

	// too little total power: calculation thrown away
	// a total equal to the floor is kept; the floor is unsigned
	assign low_pwr = total_pwr_i < words[dor_pkg::dor_slot(dor_pkg::IDX_MIN_PWR)*16 +: 16];

	// detector result registers; flags hold until the next kept calculation
	// valid and discard are one-cycle pulses, never both high; a discarded
	// calculation leaves the previous pass flags standing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_valid_reg   <= 1'b0;
			det_discard_reg <= 1'b0;
			pass_reg        <= 4'h0;
		end else begin
			det_valid_reg   <= calc_valid_i && !low_pwr;
			det_discard_reg <= calc_valid_i && low_pwr;
			if (calc_valid_i && !low_pwr) begin
				// only kept calculations move the pass flags
				pass_reg <= {col_harm, row_harm, col_dom, row_dom};
			end
		end
	end

	assign det_valid_o    = det_valid_reg;
	assign det_discard_o  = det_discard_reg;
	assign det_row_dom_o  = pass_reg[0];
	assign det_col_dom_o  = pass_reg[1];
	assign det_row_harm_o = pass_reg[2];
	assign det_col_harm_o = pass_reg[3];

	// magnitude in 17 bits so the most negative sample does not wrap
	// the hot limit is an unsigned magnitude; a sample exactly at the
	// limit keeps full gain
	assign sample_mag = sample_i[15] ? 17'(-{sample_i[15], sample_i}) : {1'b0, sample_i};
	// above the hot limit the agc drops to its lower gain step
	assign hot = sample_mag > {1'b0, words[dor_pkg::dor_slot(dor_pkg::IDX_HOT_LIMIT)*16 +: 16]};

	// two-step agc on the detector input
	// the lower step halves the sample by an arithmetic shift: cheap, and
	// the sign survives; the gain flag follows the last accepted sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			agc_valid_reg  <= 1'b0;
			agc_sample_reg <= 16'sh0000;
			agc_hot_reg    <= 1'b0;
		end else begin
			agc_valid_reg <= sample_valid_i;
			if (sample_valid_i) begin
				// without a new sample the outputs hold
				agc_hot_reg    <= hot;
				agc_sample_reg <= hot ? (sample_i >>> dor_pkg::AGC_SHIFT) : sample_i;
			end
		end
	end

	assign agc_valid_o  = agc_valid_reg;
	assign agc_sample_o = agc_sample_reg;
	assign agc_hot_o    = agc_hot_reg;

	// tone generators read their words as signed values
	// straight from the storage flops: a new word reaches the generator
	// in the cycle after the write edge, with no extra pipeline stage
	assign tone_a_freq_coef_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TA_FREQ)*16 +: 16]);
	assign tone_a_amplitude_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TA_AMP)*16 +: 16]);
	assign tone_a_initial_phase_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TA_PHASE)*16 +: 16]);
	assign tone_b_freq_coef_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TB_FREQ)*16 +: 16]);
	assign tone_b_amplitude_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TB_AMP)*16 +: 16]);
	assign tone_b_initial_phase_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_TB_PHASE)*16 +: 16]);

	// ringing generator words
	assign ring_freq_coef_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_RING_FREQ)*16 +: 16]);
	assign ring_amplitude_o     = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_RING_AMP)*16 +: 16]);
	assign ring_initial_phase_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_RING_PH)*16 +: 16]);

	// offset code: only the low six bits count, upper bits stored but unused
	// upper bits are kept so that a read returns exactly what was written
	assign ring_dc_offset_o = words[dor_pkg::dor_slot(dor_pkg::IDX_RING_OFS)*16 +: dor_pkg::RING_OFS_MSB+1];

	// offset in millivolts; code 63 gives the full-scale value
	// registered to keep the multiplier off the generator's timing path;
	// it trails a change of the offset word by one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ring_mv_reg <= 17'h00000;
		end else if (ring_dc_offset_o == 6'h3F) begin
			// top code pinned to full scale
			ring_mv_reg <= dor_pkg::RING_MAX_MV;
		end else begin
			// code times step, fits in 17 bits
			ring_mv_reg <= 17'(ring_dc_offset_o * dor_pkg::RING_STEP_MV);
		end
	end

	assign ring_dc_offset_mv_o = ring_mv_reg;

	// pulse metering words
	// same direct path as the tone and ringing words
	assign meter_ramp_rate_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_MTR_RAMP)*16 +: 16]);
	assign meter_amplitude_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_MTR_AMP)*16 +: 16]);
	assign meter_freq_coef_o = $signed(words[dor_pkg::dor_slot(dor_pkg::IDX_MTR_FREQ)*16 +: 16]);

	// read-only status word, writes to it are acked and dropped
	// captured into dat_reg one edge before ack, so a pulse flag shows
	// only if it stands at that edge
	always_comb begin
		// unused bits read as zero
		status                       = 16'h0000;
		status[dor_pkg::ST_VALID]    = det_valid_reg;
		status[dor_pkg::ST_ROW_DOM]  = pass_reg[0];
		status[dor_pkg::ST_COL_DOM]  = pass_reg[1];
		status[dor_pkg::ST_ROW_HARM] = pass_reg[2];
		status[dor_pkg::ST_COL_HARM] = pass_reg[3];
		status[dor_pkg::ST_DISCARD]  = det_discard_reg;
		status[dor_pkg::ST_AGC_HOT]  = agc_hot_reg;
		// contents are only trustworthy once every word was written
		status[dor_pkg::ST_ALL_WR]   = &written_reg;
	end
endmodule
`default_nettype wire

// ### tb/dor_indirect_bank_sva.sv
`default_nettype none
// watches bus timing, detector and agc handshakes at the bank's ports
module dor_indirect_bank_sva (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic [7:0]         adr_i,
	input wire logic [31:0]        dat_i,
	input wire logic               we_i,
	input wire logic [3:0]         sel_i,
	input wire logic               stb_i,
	input wire logic               cyc_i,
	input wire logic               ack_o,
	input wire logic               calc_valid_i,
	input wire logic               det_valid_o,
	input wire logic               det_discard_o,
	input wire logic               det_row_dom_o,
	input wire logic               det_col_dom_o,
	input wire logic               det_row_harm_o,
	input wire logic               det_col_harm_o,
	input wire logic               sample_valid_i,
	input wire logic               agc_valid_o,
	input wire logic signed [15:0] tone_a_freq_coef_o,
	input wire logic [5:0]         ring_dc_offset_o,
	input wire logic [16:0]        ring_dc_offset_mv_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// offset word written since reset; the millivolt register restarts at zero
	logic ofs_seen_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ofs_seen_reg <= 1'b0;
		end else if (ack_o && we_i && adr_i == 8'h4C && sel_i[0]) begin
			ofs_seen_reg <= 1'b1;
		end
	end
	a_ack_two_edges: assert property ($rose(cyc_i && stb_i) |-> !ack_o ##1 !ack_o ##1 ack_o)
		else $error("bus answer not two edges after request");
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("bus answer longer than one cycle");
	a_ack_in_cycle: assert property (ack_o |-> cyc_i && stb_i)
		else $error("bus answer outside a cycle");
	a_tone_write_out: assert property (ack_o && we_i && adr_i == 8'h34 && sel_i[1:0] == 2'b11
		|=> tone_a_freq_coef_o == $past(dat_i[15:0])) else $error("tone word not driven out");
	a_ring_offset_mv: assert property (ofs_seen_reg
		|=> ring_dc_offset_mv_o == 17'($past(ring_dc_offset_o)) * 17'h005DC)
		else $error("ring offset millivolts wrong");
	a_det_one_answer: assert property (calc_valid_i |=> det_valid_o != det_discard_o)
		else $error("calculation not answered once");
	a_det_has_cause: assert property (det_valid_o || det_discard_o |-> $past(calc_valid_i))
		else $error("detector answer without calculation");
	a_det_flags_hold: assert property (!det_valid_o && !$past(rst_i)
		|-> $stable({det_row_dom_o, det_col_dom_o, det_row_harm_o, det_col_harm_o}))
		else $error("detector flags moved without kept calculation");
	a_agc_answer: assert property (sample_valid_i |=> agc_valid_o)
		else $error("agc sample not answered");
	a_agc_has_cause: assert property (agc_valid_o |-> $past(sample_valid_i))
		else $error("agc answer without sample");
	c_write: cover property (ack_o && we_i);
	c_discard: cover property (det_discard_o);
	c_agc: cover property (agc_valid_o);
endmodule
bind dor_indirect_bank dor_indirect_bank_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
	.dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
	.calc_valid_i(calc_valid_i), .det_valid_o(det_valid_o), .det_discard_o(det_discard_o),
	.det_row_dom_o(det_row_dom_o), .det_col_dom_o(det_col_dom_o),
	.det_row_harm_o(det_row_harm_o), .det_col_harm_o(det_col_harm_o),
	.sample_valid_i(sample_valid_i), .agc_valid_o(agc_valid_o),
	.tone_a_freq_coef_o(tone_a_freq_coef_o), .ring_dc_offset_o(ring_dc_offset_o),
	.ring_dc_offset_mv_o(ring_dc_offset_mv_o));
`default_nettype wire

// ### tb/dor_indirect_bank_test.sv
`default_nettype none
// bench for the parameter bank: bus access, generator outputs, detector, agc
module dor_indirect_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, we_i, stb_i, cyc_i, ack_o;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [3:0]  sel_i;
	logic        calc_valid_i, sample_valid_i, agc_valid_o, agc_hot_o;
	logic [15:0] pw [0:6];    // row peak/rest, col peak/rest, row/col harmonic, total
	logic [15:0] osc [13:25]; // generator words by index, 19 unused
	logic [15:0] sample_i, agc_sample_o;
	logic [5:0]  det_o;       // valid, discard, row dom, col dom, row harm, col harm
	logic [5:0]  ofs_o;
	logic [16:0] mv_o;
	int          n_errors, check_count, cycles;
	dor_indirect_bank uut (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
		.sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o), .calc_valid_i(calc_valid_i),
		.row_peak_pwr_i(pw[0]), .row_rest_pwr_i(pw[1]), .col_peak_pwr_i(pw[2]),
		.col_rest_pwr_i(pw[3]), .row_harm_pwr_i(pw[4]), .col_harm_pwr_i(pw[5]),
		.total_pwr_i(pw[6]), .det_valid_o(det_o[0]), .det_discard_o(det_o[1]),
		.det_row_dom_o(det_o[2]), .det_col_dom_o(det_o[3]), .det_row_harm_o(det_o[4]),
		.det_col_harm_o(det_o[5]), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
		.agc_valid_o(agc_valid_o), .agc_sample_o(agc_sample_o), .agc_hot_o(agc_hot_o),
		.tone_a_freq_coef_o(osc[13]), .tone_a_amplitude_o(osc[14]),
		.tone_a_initial_phase_o(osc[15]), .tone_b_freq_coef_o(osc[16]),
		.tone_b_amplitude_o(osc[17]), .tone_b_initial_phase_o(osc[18]),
		.ring_dc_offset_o(ofs_o), .ring_dc_offset_mv_o(mv_o), .ring_freq_coef_o(osc[20]),
		.ring_amplitude_o(osc[21]), .ring_initial_phase_o(osc[22]),
		.meter_ramp_rate_o(osc[23]), .meter_amplitude_o(osc[24]), .meter_freq_coef_o(osc[25])
	);
	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// hang guard; the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// distinct negative word per index, so a swapped slot shows
	function automatic logic [15:0] wv(input int i);
		return 16'h8001 + 16'(i * 16'h0111);
	endfunction
	// one classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		sel_i <= {2'b00, s};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic t_bank();
		for (int i = 7; i <= 25; i++) begin
			wb(1'b1, 8'(4 * i), wv(i), 2'b11);
		end
		for (int i = 7; i <= 25; i++) begin
			wb(1'b0, 8'(4 * i), 16'h0000, 2'b00);
			chk(rd, {16'h0000, wv(i)});
			if (i >= 13 && i != 19) begin
				chk({16'h0000, osc[i]}, {16'h0000, wv(i)});
			end
		end
		chk({26'h0, ofs_o}, 32'h00000004);
		chk({15'h0, mv_o}, 32'h00001770);
	endtask
	// unused bits stored; byte lanes written apart
	task automatic t_bytes();
		wb(1'b1, 8'h4C, 16'hFFFF, 2'b11);
		wb(1'b0, 8'h4C, 16'h0000, 2'b11);
		chk(rd, 32'h0000FFFF);
		chk({15'h0, mv_o}, 32'h00017124);
		wb(1'b1, 8'h4C, 16'h5A00, 2'b01);
		wb(1'b1, 8'h4C, 16'h5A77, 2'b10);
		wb(1'b0, 8'h4C, 16'h0000, 2'b11);
		chk(rd, 32'h00005A00);
		chk({14'h0, mv_o, ofs_o == 6'h00}, 32'h00000001);
	endtask
	// unmapped places read zero and leave the bank alone
	task automatic t_unmapped();
		wb(1'b0, 8'h18, 16'h0000, 2'b11);
		chk(rd, 32'h00000000);
		wb(1'b1, 8'hA8, 16'h1234, 2'b11);
		wb(1'b0, 8'hA8, 16'h0000, 2'b11);
		chk(rd, 32'h00000000);
		wb(1'b0, 8'h28, 16'h0000, 2'b11);
		chk(rd, {16'h0000, wv(10)});
	endtask
	task automatic calc(input logic [111:0] p, input logic [5:0] exp);
		@(posedge clk_i);
		calc_valid_i <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			pw[k] <= p[111 - 16 * k -: 16];
		end
		@(posedge clk_i);
		calc_valid_i <= 1'b0;
		@(negedge clk_i);
		chk({26'h0, det_o}, {26'h0, exp});
	endtask
	// unity on row checks, ratio two on column checks; strict compare at the edge
	task automatic t_det();
		wb(1'b1, 8'h1C, 16'h07F0, 2'b11);
		wb(1'b1, 8'h20, 16'h0FE0, 2'b11);
		wb(1'b1, 8'h24, 16'h07F0, 2'b11);
		wb(1'b1, 8'h28, 16'h0FE0, 2'b11);
		wb(1'b1, 8'h2C, 16'h0100, 2'b11);
		calc(112'h0064_0064_00C9_0064_0063_0064_0100, 6'b111001);
		calc(112'h0064_0063_00C8_0064_0064_0064_0100, 6'b000101);
		calc(112'h0064_0064_00C9_0064_0063_0064_00FF, 6'b000110);
		wb(1'b0, 8'h68, 16'h0000, 2'b11);
		chk(rd, 32'h00000082);
	endtask
	task automatic agc(input logic [15:0] s, input logic [16:0] exp);
		@(posedge clk_i);
		sample_valid_i <= 1'b1;
		sample_i <= s;
		@(posedge clk_i);
		sample_valid_i <= 1'b0;
		@(negedge clk_i);
		chk({14'h0, agc_valid_o, agc_hot_o, agc_sample_o}, {15'h0001, exp});
	endtask
	// magnitude at the limit stays full scale, above it is halved
	task automatic t_agc();
		wb(1'b1, 8'h30, 16'h1000, 2'b11);
		agc(16'h1000, 17'h01000);
		agc(16'h1001, 17'h10800);
		agc(16'hEFFF, 17'h1F7FF);
		agc(16'hF000, 17'h0F000);
	endtask
	// mid-run reset: outputs cleared, written tracking restarts
	task automatic t_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(dat_o, 32'h00000000);
		chk({8'h00, det_o, agc_valid_o, agc_hot_o, agc_sample_o}, 32'h00000000);
		chk({15'h0, mv_o}, 32'h00000000);
		rst_i <= 1'b0;
		wb(1'b0, 8'h68, 16'h0000, 2'b11);
		chk(rd, 32'h00000000);
	endtask
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, calc_valid_i, sample_valid_i} = 5'h00;
		adr_i = 8'h00;
		dat_i = 32'h00000000;
		sel_i = 4'h0;
		sample_i = 16'h0000;
		foreach (pw[k]) pw[k] = 16'h0000;
		n_errors = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_bank();
		t_bytes();
		t_unmapped();
		t_det();
		t_agc();
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
